// ---- rtcai_map.svh ----
// Offsets, field positions, reset values and timing for alarm/irq control
// Assumes a 17-bit byte address bus and a 20 MHz core clock
`ifndef RTCAI_MAP_SVH
`define RTCAI_MAP_SVH
`define RTCAI_ADR_FLAGS 17'h1fff0
`define RTCAI_ADR_ASEC 17'h1fff2
`define RTCAI_ADR_AMIN 17'h1fff3
`define RTCAI_ADR_AHOUR 17'h1fff4
`define RTCAI_ADR_ADATE 17'h1fff5
`define RTCAI_ADR_ICTL 17'h1fff6
`define RTCAI_B_WIE 7
`define RTCAI_B_AIE 6
`define RTCAI_B_PFE 5
`define RTCAI_B_ABE 4
`define RTCAI_B_HL 3
`define RTCAI_B_PL 2
`define RTCAI_B_MASK 7
`define RTCAI_B_ZERO 6
`define RTCAI_B_WDF 7
`define RTCAI_B_AF 6
`define RTCAI_B_PF 5
`define RTCAI_RST_REG 8'h00
`define RTCAI_CLK_HZ 64'd20000000
`define RTCAI_PULSE_MS 64'd200
`endif

// ---- rtcai_pkg.sv ----
// Types shared by the alarm and interrupt control block
// Assumes nothing of its surroundings
package rtcai_pkg;
  typedef logic [7:0] rtcai_byte_t;
  typedef enum logic [1:0] {
    RTCAI_IDLE,
    RTCAI_READ,
    RTCAI_WRITE
  } rtcai_bus_t;
endpackage

// ---- rtcai_ctrl.sv ----
// Alarm match, event flags and interrupt pin control of an RTC
// Assumes bus pins and timekeeping inputs synchronous to i_clk
//
// Overview of operation
// RULE_01 - Watchdog timeout drives pin when enable set
// RULE_02 - Alarm match drives pin when enable set
// RULE_03 - Power fail drives pin when enable set
// RULE_04 - Alarm in backup only when enabled
// RULE_05 - Polarity: push-pull high or open-drain low
// RULE_06 - Pulse mode holds pin about 200 ms
// RULE_07 - Level mode holds pin until flags read
// RULE_08 - Control bits 1 and 0 unused
// RULE_09 - Date alarm: mask, zero, tens, units
// RULE_10 - Date mask zero includes date in match
// RULE_11 - Hours alarm: mask, zero, digits, mask selects
// RULE_12 - Minutes alarm: mask bit, digits, mask selects
// RULE_13 - Seconds alarm: mask bit and digits
// RULE_14 - Seconds mask zero includes seconds
// RULE_15 - Alarm flag on match, cleared on read
// RULE_16 - Watchdog flag on timeout, cleared on read
// RULE_17 - Power-fail flag on fall, cleared on read
// RULE_18 - BCD compare once per seconds update
`timescale 1ns/1ps
`include "rtcai_map.svh"
module rtcai_ctrl #(
  parameter int unsigned PULSE_CYC =
    int'((`RTCAI_PULSE_MS * `RTCAI_CLK_HZ) / 64'd1000)
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  input wire logic [6:0] i_now_sec,
  input wire logic [6:0] i_now_min,
  input wire logic [6:0] i_now_hour,
  input wire logic [6:0] i_now_date,
  input wire logic i_sec_tick,
  input wire logic i_wdog_timeout,
  input wire logic i_pwr_fail,
  output logic o_int,
  output logic o_int_oe
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [16:0] a,
                               input logic [16:0] t);
    hit = (a == t);
  endfunction

  rtcai_pkg::rtcai_bus_t st_q;
  rtcai_pkg::rtcai_bus_t st_d;
  logic [16:0] adr_q;
  rtcai_pkg::rtcai_byte_t wdat_q;
  rtcai_pkg::rtcai_byte_t alm_q [4];
  rtcai_pkg::rtcai_byte_t ctl_q;
  logic wdf_q;
  logic af_q;
  logic pf_q;
  logic pwr_q;
  logic lvl_q;
  logic [21:0] pls_q;
  logic [21:0] pls_d;
  logic int_on_d;

  wire rd_act = !i_ce_n && i_we_n && !i_oe_n;
  wire wr_act = !i_ce_n && !i_we_n;
  wire wr_done = (st_q == rtcai_pkg::RTCAI_WRITE) && !wr_act;
  wire rd_done = (st_q == rtcai_pkg::RTCAI_READ) && !rd_act;
  wire flags_clr = rd_done && hit(adr_q, `RTCAI_ADR_FLAGS);

  wire [16:0] adr_tab [4] = '{`RTCAI_ADR_ASEC, `RTCAI_ADR_AMIN,
                              `RTCAI_ADR_AHOUR, `RTCAI_ADR_ADATE};
  wire [6:0] now_tab [4] = '{i_now_sec, i_now_min,
                             i_now_hour, i_now_date};

  wire watchdog_irq_enable = ctl_q[`RTCAI_B_WIE];
  wire alarm_irq_enable = ctl_q[`RTCAI_B_AIE];
  wire powerfail_irq_enable = ctl_q[`RTCAI_B_PFE];
  wire abe = ctl_q[`RTCAI_B_ABE];
  wire hl = ctl_q[`RTCAI_B_HL];
  wire pl = ctl_q[`RTCAI_B_PL];

  // ----------------------------------------
  // Bus cycle tracking
  // ----------------------------------------
  always_comb
  begin
    st_d = rtcai_pkg::RTCAI_IDLE;
    if (wr_act)
      st_d = rtcai_pkg::RTCAI_WRITE;
    else if (rd_act)
      st_d = rtcai_pkg::RTCAI_READ;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= rtcai_pkg::RTCAI_IDLE;
      adr_q <= 17'h00000;
      wdat_q <= `RTCAI_RST_REG;
    end
    else
    begin
      st_q <= st_d;
      if (wr_act || rd_act)
        adr_q <= i_addr;
      if (wr_act)
        wdat_q <= i_dq;
    end
  end

  // ----------------------------------------
  // Alarm registers and match
  // ----------------------------------------
  logic [3:0] fld_ok;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_alm
      // Hours and date keep bit 6 at zero
      wire rsv = (gi >= 2);
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          alm_q[gi] <= `RTCAI_RST_REG;
        else if (wr_done && hit(adr_q, adr_tab[gi]))
          alm_q[gi] <= {wdat_q[7], wdat_q[6] & !rsv,
                        wdat_q[5:0]}; // [RULE_09] [RULE_11] [RULE_12] [RULE_13]
      end
      assign fld_ok[gi] = alm_q[gi][`RTCAI_B_MASK] ||
                          (alm_q[gi][6:0] == now_tab[gi]); // [RULE_10] [RULE_14] [RULE_18]
    end
  endgenerate

  wire alm_ok = abe || !i_pwr_fail; // [RULE_04]
  wire alm_evt = i_sec_tick && (&fld_ok) && alm_ok; // [RULE_15] [RULE_18]
  wire pf_evt = i_pwr_fail && !pwr_q; // [RULE_17]
  wire int_evt = (watchdog_irq_enable && i_wdog_timeout) || // [RULE_01]
                 (alarm_irq_enable && alm_evt) || // [RULE_02]
                 (powerfail_irq_enable && pf_evt); // [RULE_03]

  // ----------------------------------------
  // Control and flags
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctl_q <= `RTCAI_RST_REG;
      wdf_q <= 1'b0;
      af_q <= 1'b0;
      pf_q <= 1'b0;
      pwr_q <= 1'b0;
    end
    else
    begin
      if (wr_done && hit(adr_q, `RTCAI_ADR_ICTL))
        ctl_q <= {wdat_q[7:2], 2'b00}; // [RULE_08]
      wdf_q <= i_wdog_timeout || (wdf_q && !flags_clr); // [RULE_16]
      af_q <= alm_evt || (af_q && !flags_clr); // [RULE_15]
      pf_q <= pf_evt || (pf_q && !flags_clr); // [RULE_17]
      pwr_q <= i_pwr_fail;
    end
  end

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  always_comb
  begin
    pls_d = pls_q;
    if (int_evt && pl)
      pls_d = PULSE_CYC[21:0]; // [RULE_06]
    else if (pls_q != 22'h000000)
      pls_d = pls_q - 22'h000001;
  end

  assign int_on_d = pl ? (pls_d != 22'h000000) : // [RULE_06]
                    (int_evt || (lvl_q && !flags_clr)); // [RULE_07]

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lvl_q <= 1'b0;
      pls_q <= 22'h000000;
      o_int <= 1'b0;
      o_int_oe <= 1'b0;
    end
    else
    begin
      lvl_q <= (int_evt && !pl) || (lvl_q && !flags_clr); // [RULE_07]
      pls_q <= pls_d;
      o_int <= hl && int_on_d; // [RULE_05]
      o_int_oe <= hl || int_on_d; // [RULE_05]
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  rtcai_pkg::rtcai_byte_t rdat;
  always_comb
  begin
    rdat = 8'h00;
    if (hit(i_addr, `RTCAI_ADR_FLAGS))
      rdat = {wdf_q, af_q, pf_q, 5'h00};
    else if (hit(i_addr, `RTCAI_ADR_ICTL))
      rdat = ctl_q;
    for (int k = 0; k < 4; k++)
      if (hit(i_addr, adr_tab[k]))
        rdat = alm_q[k];
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_dq <= 8'h00;
      o_dq_oe <= 1'b0;
    end
    else
    begin
      o_dq <= rd_act ? rdat : 8'h00;
      o_dq_oe <= rd_act;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_wdog_pin;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_wdog_timeout && watchdog_irq_enable && !pl |=> lvl_q && (o_int || o_int_oe);
  endproperty
  a_wdog_pin: assert property (p_wdog_pin) // [RULE_01]
    else $error("watchdog timeout did not raise pin");

  property p_alm_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
    alm_evt |=> af_q;
  endproperty
  a_alm_flag: assert property (p_alm_flag) // [RULE_15]
    else $error("alarm match did not set flag");

  property p_pf_pin;
    @(posedge i_clk) disable iff (!i_rst_n)
    pf_evt && powerfail_irq_enable && !pl |=> lvl_q && pf_q;
  endproperty
  a_pf_pin: assert property (p_pf_pin) // [RULE_03]
    else $error("power fail did not raise pin");

  property p_backup;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_pwr_fail && !abe |-> !alm_evt;
  endproperty
  a_backup: assert property (p_backup) // [RULE_04]
    else $error("alarm fired in backup without enable");

  property p_odrain;
    @(posedge i_clk) disable iff (!i_rst_n)
    !hl && !int_evt |=> !o_int;
  endproperty
  a_odrain: assert property (p_odrain) // [RULE_05]
    else $error("open-drain pin driven high");

  property p_pulse;
    @(posedge i_clk) disable iff (!i_rst_n)
    int_evt && pl |=> pls_q == PULSE_CYC[21:0] ##1 pls_q != 22'h000000;
  endproperty
  a_pulse: assert property (p_pulse) // [RULE_06]
    else $error("pulse length not loaded");

  property p_level;
    @(posedge i_clk) disable iff (!i_rst_n)
    lvl_q && !flags_clr |=> lvl_q;
  endproperty
  a_level: assert property (p_level) // [RULE_07]
    else $error("level interrupt dropped without read");

  property p_date_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |-> alm_q[3][6] == 1'b0 && alm_q[2][6] == 1'b0;
  endproperty
  a_date_zero: assert property (p_date_zero) // [RULE_09]
    else $error("fixed zero bit set in alarm register");

  property p_wdf;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_wdog_timeout |=> wdf_q;
  endproperty
  a_wdf: assert property (p_wdf) // [RULE_16]
    else $error("watchdog flag not set");

endmodule

// ---- rtcai_host.sv ----
// Host model on the asynchronous byte-wide memory bus
// Assumes the device samples the bus pins at the rising clock edge
`timescale 1ns/1ps
module rtcai_host (
  input wire logic i_clk,
  output logic [16:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  input wire logic [7:0] i_dq
);
  initial
  begin
    o_addr = 17'h00000;
    o_dq = 8'h00;
    o_ce_n = 1'b1;
    o_we_n = 1'b1;
    o_oe_n = 1'b1;
  end

  // One active cycle, then idle; released data shows no stale value
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_dq = d;
    o_ce_n = 1'b0;
    o_we_n = 1'b0;
    @(posedge i_clk);
    #1;
    o_ce_n = 1'b1;
    o_we_n = 1'b1;
    o_dq = ~d;
    @(posedge i_clk);
  endtask

  // Reading the flags register is what releases a level interrupt
  task automatic rd(input logic [16:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_ce_n = 1'b0;
    o_oe_n = 1'b0;
    @(posedge i_clk);
    #1;
    d = i_dq;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    @(posedge i_clk);
  endtask
endmodule

// ---- tb_rtc_alarm_interrupt_control.sv ----
// Self-checking bench for the alarm and interrupt control block
// Assumes rtcai_host drives the bus; events come from this bench
`timescale 1ns/1ps
`include "rtcai_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rtc_alarm_interrupt_control;
  localparam int PULSE = 20;
  logic i_clk = 0, i_rst_n = 0, tick = 0, wdog = 0, pwr = 0;
  logic [16:0] addr;
  logic [7:0] wd, o_dq, r;
  logic ce_n, we_n, oe_n, o_dq_oe, o_int, o_int_oe;
  logic [6:0] now [4];
  int num_errors = 0, num_checks = 0, seed = 94780, n, fl;
  int msk [5] = '{8'hff, 8'hff, 8'hbf, 8'hbf, 8'hfc};
  int m_reg [5];
  int m_flags = 0;
  int exp_q [$];

  rtcai_ctrl #(.PULSE_CYC(PULSE)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(addr), .i_dq(wd), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_now_sec(now[0]), .i_now_min(now[1]),
    .i_now_hour(now[2]), .i_now_date(now[3]), .i_sec_tick(tick),
    .i_wdog_timeout(wdog), .i_pwr_fail(pwr), .o_int(o_int),
    .o_int_oe(o_int_oe));
  rtcai_host i_host (.i_clk(i_clk), .o_addr(addr), .o_dq(wd), .o_ce_n(ce_n),
    .o_we_n(we_n), .o_oe_n(oe_n), .i_dq(o_dq));

  initial
  forever #25 i_clk = ~i_clk;

  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Model of the match: every field masked or equal to the time now
  function automatic bit alm_match();
    alm_match = 1'b1;
    for (int i = 0; i < 4; i++)
      if (!m_reg[i][7] && m_reg[i][6:0] != now[i])
        alm_match = 1'b0;
  endfunction

  // Register write that also keeps the model copy
  task automatic put(input int i, input logic [7:0] d);
    i_host.wr(`RTCAI_ADR_ASEC + 17'(i), d);
    m_reg[i] = d & msk[i][7:0];
  endtask

  // Flags read: compared with the model, which the read then clears
  task automatic rd_flags;
    i_host.rd(`RTCAI_ADR_FLAGS, r);
    `CHK(r, m_flags[7:0])
    m_flags = 0;
  endtask

  // One-cycle event: 0 watchdog, 1 seconds tick, 2 supply drop
  task automatic ev(input int s);
    @(posedge i_clk);
    #1;
    wdog = (s == 0);
    tick = (s == 1);
    if (s == 0)
      m_flags |= 'h80;
    if (s == 1 && alm_match() && (m_reg[4][4] || !pwr))
      m_flags |= 'h40;
    if (s == 2 && !pwr)
      m_flags |= 'h20;
    if (s == 2)
      pwr = 1'b1;
    @(posedge i_clk);
    #1;
    wdog = 1'b0;
    tick = 1'b0;
  endtask

  task automatic all_masked;
    for (int i = 0; i < 4; i++)
      put(i, 8'h80);
  endtask

  initial
  begin
    #500000;
    num_errors++;
    final_report;
  end

  initial
  begin
    for (int i = 0; i < 4; i++)
      now[i] = 7'h00;
    repeat (5) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    `CHK({o_int, o_int_oe, o_dq_oe}, 3'b000)
    for (int i = 0; i < 5; i++)
    begin
      n = $random(seed);
      put(i, n[7:0]);
      exp_q.push_back(m_reg[i]);
    end
    for (int i = 0; i < 5; i++)
    begin
      i_host.rd(`RTCAI_ADR_ASEC + 17'(i), r);
      fl = exp_q.pop_front();
      `CHK(r, fl[7:0])
    end
    rd_flags;
    `CHK(r, 8'h00)
    all_masked;
    for (int k = 0; k < 6; k++)
    begin
      fl = 8'h80 >> (k % 3);
      put(4, (k < 3 ? 8'h00 : fl[7:0]) | 8'h08);
      ev(k % 3);
      `CHK({o_int, o_int_oe}, {k > 2, 1'b1})
      rd_flags;
      `CHK(r, fl[7:0])
      #1 pwr = 1'b0;
      repeat (2) @(posedge i_clk);
      #1 `CHK(o_int, 1'b0)
    end
    put(4, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        n = $random(seed);
        put(i, i == k / 2 ? 8'h25 : 8'h80);
        #1;
        now[i] = (i == k / 2) ? 7'h25 - 7'(k % 2) : 7'({n[5:4], 1'b0, n[2:0]});
      end
      ev(1);
      rd_flags;
      `CHK(r, k % 2 ? 8'h00 : 8'h40)
    end
    all_masked;
    put(4, 8'h48);
    ev(2);
    ev(1);
    `CHK(o_int, 1'b0)
    rd_flags;
    `CHK(r, 8'h20)
    put(4, 8'h58);
    ev(1);
    `CHK(o_int, 1'b1)
    rd_flags;
    #1 pwr = 1'b0;
    put(4, 8'h8c);
    `CHK(o_int, 1'b0)
    ev(0);
    n = 0;
    while (o_int === 1'b1 && n < 99)
    begin
      n++;
      @(posedge i_clk);
      #1;
    end
    `CHK(n, PULSE)
    rd_flags;
    put(4, 8'h80);
    ev(0);
    `CHK({o_int, o_int_oe}, 2'b01)
    rd_flags;
    repeat (2) @(posedge i_clk);
    #1 `CHK(o_int_oe, 1'b0)
    final_report;
  end
endmodule
